// File: design/ttc_pkg.sv
`default_nettype none
package ttc_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] CTRL_OFFS = 4'h0;
    localparam logic [3:0] STAT_OFFS = 4'h4;
    localparam int ADDR_W = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_MODE_HI = 2;
    localparam int STAT_SUP_LSB = 0;
    localparam int STAT_LOAD_LSB = 4;
    localparam int STAT_NOTRIG_BIT = 6;
    localparam int STAT_MSW_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Machine-state word layout
    // ****************************************
    localparam int MSW_W = 16;
    localparam int MSW_SUP_LSB = 0;
    localparam int MSW_LOAD_LSB = 4;
    localparam int MSW_MODE_LSB = 6;
    localparam int MSW_RUN_BIT = 8;
    localparam int MSW_ACK_BIT = 9;
    localparam int MSW_HIT_BIT = 10;

    // ****************************************
    // Memory strobe vector positions
    // ****************************************
    localparam int STB_W = 8;
    localparam int STB_MASK_SEL = 0;
    localparam int STB_MASK_OE = 1;
    localparam int STB_MASK_WE = 2;
    localparam int STB_MASK_ACK = 3;
    localparam int STB_PAT_SEL = 4;
    localparam int STB_PAT_OE = 5;
    localparam int STB_PAT_WE = 6;
    localparam int STB_PAT_ACK = 7;
    localparam logic [7:0] STB_IDLE = 8'h00;
    localparam logic [7:0] STB_WRITE = 8'h55;
    localparam logic [7:0] STB_ADDR = 8'h99;
    localparam logic [7:0] STB_CMP = 8'h33;
    localparam int SUP_STATES = 9;

    typedef enum logic [3:0] {
        st_idle, st_trig, st_trace_during_detect, st_trace_up_to_detect,
        st_trace_after_detect, st_trace_between_detect, st_spare6,
        st_spare7, st_done
    } ttc_sup_t;

    typedef enum logic [1:0] {
        ld_idle, ld_write, ld_addr, ld_wait
    } ttc_load_t;
endpackage
`default_nettype wire

// File: design/ttc_load_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ttc_load_if;
    logic trigger_ready;
    logic hit;
    logic [1:0] state;
    logic [7:0] strobes;
    modport fsm (input trigger_ready, input hit, output state,
        output strobes);
    modport ctrl (output trigger_ready, output hit, input state,
        input strobes);
endinterface
`default_nettype wire

// File: design/ttc_msw_reg.sv
`timescale 1ns/1ps
`default_nettype none
module ttc_msw_reg (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] word_d,
    output logic [15:0] word_q
);
    // Registered so pins never show decode transients
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            word_q <= 16'h0000;
        else
            word_q <= word_d;
    end
endmodule // ttc_msw_reg
`default_nettype wire

// File: design/ttc_load_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module ttc_load_fsm (
    input wire logic aclk,
    input wire logic aresetn,
    ttc_load_if.fsm lif
);
    ttc_pkg::ttc_load_t st_q;
    ttc_pkg::ttc_load_t st_d;
    logic [7:0] stb_q;
    logic [7:0] stb_d;

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            ttc_pkg::ld_idle:
                if (lif.trigger_ready)
                    st_d = ttc_pkg::ld_write;
            ttc_pkg::ld_write:
                st_d = ttc_pkg::ld_addr;
            ttc_pkg::ld_addr:
                st_d = ttc_pkg::ld_wait;
            ttc_pkg::ld_wait:
                if (lif.hit)
                    st_d = ttc_pkg::ld_idle;
        endcase
    end

    always_comb
    begin
        unique case (st_d)
            ttc_pkg::ld_idle:
                stb_d = ttc_pkg::STB_IDLE;
            ttc_pkg::ld_write:
                stb_d = ttc_pkg::STB_WRITE;
            ttc_pkg::ld_addr:
                stb_d = ttc_pkg::STB_ADDR;
            ttc_pkg::ld_wait:
                stb_d = ttc_pkg::STB_CMP;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= ttc_pkg::ld_idle;
            stb_q <= 8'h00;
        end
        else
        begin
            st_q <= st_d;
            stb_q <= stb_d;
        end
    end

    assign lif.state = st_q;
    assign lif.strobes = stb_q;

    a_load_start: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == ttc_pkg::ld_idle && lif.trigger_ready
        |=> st_q == ttc_pkg::ld_write)
        else $error("load machine did not leave idle");
    a_load_idle_quiet: assert property (@(posedge aclk)
        disable iff (!aresetn)
        st_q == ttc_pkg::ld_idle |-> stb_q == 8'h00)
        else $error("strobes active in idle");
    c_load_cycle: cover property (@(posedge aclk) disable iff (!aresetn)
        st_q == ttc_pkg::ld_wait && lif.hit ##1 st_q == ttc_pkg::ld_idle);
endmodule // ttc_load_fsm
`default_nettype wire

// File: design/ttc_ctrl_top.sv
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ttc_ctrl_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trigger_ready,
    input wire logic trigger_hit,
    input wire logic trigger_ack,
    input wire logic trace_done,
    output logic mask_mem_select,
    output logic mask_mem_out_en,
    output logic mask_mem_write_en,
    output logic mask_mem_addr_clk,
    output logic pattern_mem_select,
    output logic pattern_mem_out_en,
    output logic pattern_mem_write_en,
    output logic pattern_mem_addr_clk,
    output logic [15:0] machine_state_word
);
    // ****************************************
    // Declarations
    // ****************************************
    logic por;
    logic run;
    logic mode_select_lo;
    logic mode_select_hi;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic aw_held_q;
    logic aw_held_d;
    logic [3:0] awaddr_q;
    logic [3:0] awaddr_d;
    logic w_held_q;
    logic w_held_d;
    logic [31:0] wdata_q;
    logic [31:0] wdata_d;
    logic [3:0] wstrb_q;
    logic [3:0] wstrb_d;
    logic bvalid_q;
    logic bvalid_d;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;
    logic rvalid_q;
    logic rvalid_d;
    logic [1:0] rresp_q;
    logic [1:0] rresp_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic do_write;
    logic [31:0] stat_word;
    ttc_pkg::ttc_sup_t sup_q;
    ttc_pkg::ttc_sup_t sup_d;
    logic [8:0] analyzer_state_decode;
    logic trace_during_detect;
    logic trace_up_to_detect;
    logic trace_after_detect;
    logic trace_between_detect;
    logic no_trigger_cond;
    logic [15:0] msw_d;
    ttc_load_if lif ();

    // ****************************************
    // Run control
    // ****************************************
    assign por = !aresetn;
    assign run = ctrl_q[ttc_pkg::CTRL_RUN_BIT];
    assign mode_select_lo = ctrl_q[ttc_pkg::CTRL_MODE_LO];
    assign mode_select_hi = ctrl_q[ttc_pkg::CTRL_MODE_HI];

    // Mode terms all need run and no reset
    assign trace_during_detect = !mode_select_hi && !mode_select_lo
        && run && !por;
    assign trace_up_to_detect = !mode_select_hi && mode_select_lo
        && run && !por;
    assign trace_after_detect = mode_select_hi && !mode_select_lo
        && run && !por;
    assign trace_between_detect = mode_select_hi && mode_select_lo
        && run && !por;

    // ****************************************
    // Qualified state decodes
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < ttc_pkg::SUP_STATES; gi++)
        begin : g_dec
            // Decode gated by reset and run
            assign analyzer_state_decode[gi] = !por && run
                && (sup_q == 4'(gi));
        end
    endgenerate

    assign no_trigger_cond = !por && !trigger_hit
        && analyzer_state_decode[1];

    // ****************************************
    // Supervisory machine
    // ****************************************
    always_comb
    begin
        sup_d = sup_q;
        unique case (sup_q)
            ttc_pkg::st_idle:
                if (trace_during_detect || trace_up_to_detect
                    || trace_after_detect || trace_between_detect)
                    sup_d = ttc_pkg::st_trig;
            ttc_pkg::st_trig:
                if (!run)
                    sup_d = ttc_pkg::st_idle;
                else if (trigger_ack)
                begin
                    if (trace_during_detect)
                        sup_d = ttc_pkg::st_trace_during_detect;
                    else if (trace_up_to_detect)
                        sup_d = ttc_pkg::st_trace_up_to_detect;
                    else if (trace_after_detect)
                        sup_d = ttc_pkg::st_trace_after_detect;
                    else
                        sup_d = ttc_pkg::st_trace_between_detect;
                end
            ttc_pkg::st_trace_during_detect,
            ttc_pkg::st_trace_up_to_detect,
            ttc_pkg::st_trace_after_detect,
            ttc_pkg::st_trace_between_detect:
                if (!run)
                    sup_d = ttc_pkg::st_idle;
                else if (trace_done)
                    sup_d = ttc_pkg::st_done;
            ttc_pkg::st_done:
                // Holds until software drops run, so a result is never lost
                if (!run)
                    sup_d = ttc_pkg::st_idle;
            default:
                // Spare and illegal codes recover to idle
                sup_d = ttc_pkg::st_idle;
        endcase
    end

    // Four state bits, zero at reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sup_q <= ttc_pkg::st_idle;
        else
            sup_q <= sup_d;
    end

    // ****************************************
    // Loading machine and strobes
    // ****************************************
    // Loading only starts in detection state
    assign lif.trigger_ready = trigger_ready && analyzer_state_decode[1];
    assign lif.hit = trigger_hit;

    ttc_load_fsm u_load (
        .aclk(aclk),
        .aresetn(aresetn),
        .lif(lif.fsm)
    );

    assign mask_mem_select = lif.strobes[ttc_pkg::STB_MASK_SEL];
    assign mask_mem_out_en = lif.strobes[ttc_pkg::STB_MASK_OE];
    assign mask_mem_write_en = lif.strobes[ttc_pkg::STB_MASK_WE];
    assign mask_mem_addr_clk = lif.strobes[ttc_pkg::STB_MASK_ACK];
    assign pattern_mem_select = lif.strobes[ttc_pkg::STB_PAT_SEL];
    assign pattern_mem_out_en = lif.strobes[ttc_pkg::STB_PAT_OE];
    assign pattern_mem_write_en = lif.strobes[ttc_pkg::STB_PAT_WE];
    assign pattern_mem_addr_clk = lif.strobes[ttc_pkg::STB_PAT_ACK];

    // ****************************************
    // Machine-state word
    // ****************************************
    always_comb
    begin
        msw_d = 16'h0000;
        msw_d[ttc_pkg::MSW_SUP_LSB +: 4] = sup_d;
        msw_d[ttc_pkg::MSW_LOAD_LSB +: 2] = u_load.st_d;
        msw_d[ttc_pkg::MSW_MODE_LSB +: 2] = {mode_select_hi, mode_select_lo};
        msw_d[ttc_pkg::MSW_RUN_BIT] = run;
        msw_d[ttc_pkg::MSW_ACK_BIT] = trigger_ack;
        msw_d[ttc_pkg::MSW_HIT_BIT] = trigger_hit;
    end

    ttc_msw_reg u_msw (
        .aclk(aclk),
        .aresetn(aresetn),
        .word_d(msw_d),
        .word_q(machine_state_word)
    );

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    assign do_write = aw_held_q && w_held_q && !bvalid_q;

    always_comb
    begin
        stat_word = 32'h0000_0000;
        stat_word[ttc_pkg::STAT_SUP_LSB +: 4] = sup_q;
        stat_word[ttc_pkg::STAT_LOAD_LSB +: 2] = lif.state;
        stat_word[ttc_pkg::STAT_NOTRIG_BIT] = no_trigger_cond;
        stat_word[ttc_pkg::STAT_MSW_LSB +: 16] = machine_state_word;
    end

    always_comb
    begin
        aw_held_d = aw_held_q;
        awaddr_d = awaddr_q;
        w_held_d = w_held_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        ctrl_d = ctrl_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = ttc_pkg::RESP_OKAY;
            if (awaddr_q == ttc_pkg::CTRL_OFFS)
            begin
                // Only the low byte holds bits
                if (wstrb_q[0])
                    ctrl_d = {29'h0, wdata_q[2:0]};
            end
            else if (awaddr_q != ttc_pkg::STAT_OFFS)
                bresp_d = ttc_pkg::RESP_SLVERR;
        end
        else if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_d = 1'b1;
            rresp_d = ttc_pkg::RESP_OKAY;
            if (s_axi_araddr == ttc_pkg::CTRL_OFFS)
                rdata_d = ctrl_q;
            else if (s_axi_araddr == ttc_pkg::STAT_OFFS)
                rdata_d = stat_word;
            else
            begin
                rdata_d = 32'h0000_0000;
                rresp_d = ttc_pkg::RESP_SLVERR;
            end
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            awaddr_q <= 4'h0;
            w_held_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            ctrl_q <= ttc_pkg::CTRL_RESET;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            aw_held_q <= aw_held_d;
            awaddr_q <= awaddr_d;
            w_held_q <= w_held_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            ctrl_q <= ctrl_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // ****************************************
    // Checks
    // ****************************************
    a_reset_zero: assert property (@(posedge aclk)
        !aresetn |=> sup_q == ttc_pkg::st_idle && lif.state == 2'h0)
        else $error("state not cleared by reset");
    a_sup_range: assert property (@(posedge aclk) disable iff (!aresetn)
        sup_q <= 4'h8)
        else $error("supervisory state out of range");
    a_load_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        lif.state == 2'h0 && $past(lif.state) == 2'h0
        && sup_q != ttc_pkg::st_trig |=> lif.state == 2'h0)
        else $error("loading started outside detection");
    a_decode_run: assert property (@(posedge aclk) disable iff (!aresetn)
        !run |-> analyzer_state_decode == 9'h000)
        else $error("decode active without run");
    a_msw_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 machine_state_word[3:0] == sup_q)
        else $error("state word lags supervisory state");
    a_run_start: assert property (@(posedge aclk) disable iff (!aresetn)
        sup_q == ttc_pkg::st_idle && run |=> sup_q == ttc_pkg::st_trig)
        else $error("run did not start detection");
    a_ack_trace: assert property (@(posedge aclk) disable iff (!aresetn)
        sup_q == ttc_pkg::st_trig && run && trigger_ack
        |=> sup_q == ttc_pkg::ttc_sup_t'({2'b00, $past(ctrl_q[2:1])}
        + 4'h2))
        else $error("acknowledge did not start mode trace");
    a_strobe_reg: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(mask_mem_write_en) |-> $changed(lif.state))
        else $error("strobe changed without state change");
    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("write not answered");
    c_run_trig: cover property (@(posedge aclk) disable iff (!aresetn)
        sup_q == ttc_pkg::st_idle ##1 sup_q == ttc_pkg::st_trig);
    c_trace_done: cover property (@(posedge aclk) disable iff (!aresetn)
        sup_q == ttc_pkg::st_trace_between_detect ##1
        sup_q == ttc_pkg::st_done);
    c_bad_addr: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rresp == ttc_pkg::RESP_SLVERR);
endmodule // ttc_ctrl_top
`default_nettype wire

// File: dv/ttc_trig_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Trigger memories and detect partner
// ****************************************
module ttc_trig_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic en,
    input wire logic [1:0] n_trig,
    input wire logic [3:0] wait_len,
    input wire logic in_wait,
    output logic trigger_ready,
    output logic trigger_hit,
    output logic trigger_ack
);
    logic [1:0] hits;
    logic [3:0] cnt;
    initial trigger_hit = 1'b0;
    // Hit is a one-cycle pulse, never held for the design
    always @(posedge aclk)
    begin
        trigger_hit <= 1'b0;
        if (!aresetn || !en)
        begin
            hits <= 2'h0;
            cnt <= 4'h0;
        end
        else if (in_wait && !trigger_hit)
        begin
            cnt <= cnt + 4'h1;
            if (cnt == wait_len)
            begin
                trigger_hit <= 1'b1;
                hits <= hits + 2'h1;
                cnt <= 4'h0;
            end
        end
    end
    assign trigger_ready = en && (hits < n_trig);
    assign trigger_ack = en && (hits == n_trig);
endmodule // ttc_trig_model
`default_nettype wire

// File: dv/test_trace_trigger_control_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module test_trace_trigger_control_fsm;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0] r;
    } ttc_exp_t;
    localparam logic [1:0] OK = ttc_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = ttc_pkg::RESP_SLVERR;
    localparam logic [3:0] CTRL = ttc_pkg::CTRL_OFFS;
    localparam logic [3:0] STAT = ttc_pkg::STAT_OFFS;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, trace_done = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, trigger_ready, trigger_hit, trigger_ack;
    logic [1:0] s_axi_bresp, s_axi_rresp, n_trig = 2'h1, ld_prev = 2'h0;
    logic [31:0] s_axi_rdata, st_exp;
    logic [15:0] msw;
    logic [3:0] wait_len = 4'h0;
    logic en = 1'b0;
    wire [7:0] stb;
    logic [7:0] stb_tab [4] = '{ttc_pkg::STB_IDLE, ttc_pkg::STB_WRITE,
        ttc_pkg::STB_ADDR, ttc_pkg::STB_CMP};
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    int mode;
    ttc_exp_t e;
    ttc_exp_t rq[$];
    ttc_exp_t bq[$];

    ttc_ctrl_top u_ttc_ctrl_top (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .trigger_ready, .trigger_hit,
        .trigger_ack, .trace_done, .mask_mem_select(stb[0]),
        .mask_mem_out_en(stb[1]), .mask_mem_write_en(stb[2]),
        .mask_mem_addr_clk(stb[3]), .pattern_mem_select(stb[4]),
        .pattern_mem_out_en(stb[5]), .pattern_mem_write_en(stb[6]),
        .pattern_mem_addr_clk(stb[7]), .machine_state_word(msw)
    );
    ttc_trig_model u_ttc_trig_model (
        .aclk, .aresetn, .en, .n_trig, .wait_len,
        .in_wait(stb[1] && stb[5]), .trigger_ready, .trigger_hit,
        .trigger_ack
    );

    initial
    begin
        forever #5 aclk = ~aclk;
    end

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic fail(input string s);
        err_total++;
        $display("wrong value at %0t: %s", $time, s);
    endtask
    task automatic chk_st(input logic [31:0] g, x);
        total_checks++;
        if (g !== x) fail("state or strobe");
    endtask
    task automatic chk_rd(input logic [31:0] g, input logic [1:0] r);
        total_checks++;
        if (g !== e.d || r !== e.r) fail("read data or response");
    endtask
    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask
    // Expects to be entered just after a rising edge
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] r);
        bq.push_back('{32'h0, 32'h0, r});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, m,
        input logic [1:0] r);
        rq.push_back('{d, m, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic wait_msw(input logic [15:0] m, v);
        for (int n = 0; n < 400 && (msw & m) !== v; n++) @(posedge aclk);
        chk_st(msw & m, v);
    endtask

    // Ceiling far above the few hundred cycles the tests need
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end

    // Watcher: oldest note against each result as it appears
    always @(posedge aclk)
    begin
        if (s_axi_bvalid && s_axi_bready)
        begin
            e = bq.pop_front();
            chk_st(s_axi_bresp, e.r);
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            e = rq.pop_front();
            chk_rd(s_axi_rdata & e.m, s_axi_rresp);
        end
        if (aresetn)
        begin
            chk_st(stb, stb_tab[msw[5:4]]);
            if (ld_prev inside {2'h1, 2'h2})
                chk_st(msw[5:4], ld_prev + 1);
        end
        ld_prev <= msw[5:4];
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'hc488be09));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_st({msw, stb}, 32'h0);
        axi_rd(CTRL, ttc_pkg::CTRL_RESET, 32'hffff_ffff, OK);
        axi_rd(STAT, 32'h0, 32'hffff_ffbf, OK);
        end_test("reset");
        axi_rd(4'h8, 32'h0, 32'hffff_ffff, ERR);
        axi_wr(4'hc, $urandom, ERR);
        axi_wr(STAT, $urandom, OK);
        axi_rd(STAT, 32'h0, 32'hffff_ffbf, OK);
        end_test("refusal");
        for (mode = 0; mode < 4; mode++)
        begin
            n_trig <= 2'($urandom_range(3, 1));
            wait_len <= 4'($urandom_range(7, 0));
            // Ready offered while the supervisor idles must be ignored
            en <= 1'b1;
            repeat (3) @(posedge aclk);
            chk_st(msw[5:4], 32'h0);
            axi_wr(CTRL, {24'($urandom), 5'h0, 2'(mode), 1'b1}, OK);
            wait_msw(16'h000f, 16'h0001);
            wait_msw(16'h0030, 16'h0010);
            axi_rd(CTRL, {29'h0, 2'(mode), 1'b1}, 32'h7, OK);
            wait_msw(16'h000f, 16'(mode + 2));
            chk_st(msw[8:6], {1'b1, 2'(mode)});
            // Ack still high, hit pulse long gone by the read
            st_exp = {5'h0, 1'b0, 1'b1, 1'b1, 2'(mode), 2'h0, 4'(mode + 2),
                12'h0, 4'(mode + 2)};
            axi_rd(STAT, st_exp, 32'h07ff_007f, OK);
            trace_done <= 1'b1;
            wait_msw(16'h000f, 16'h0008);
            trace_done <= 1'b0;
            axi_wr(CTRL, 32'h0, OK);
            wait_msw(16'h000f, 16'h0000);
            en <= 1'b0;
            // One edge with the partner off clears its hit count
            @(posedge aclk);
            end_test("mode");
        end
        n_trig <= 2'h3;
        wait_len <= 4'hf;
        axi_wr(CTRL, 32'h0000_0007, OK);
        en <= 1'b1;
        wait_msw(16'h003f, 16'h0031);
        axi_wr(CTRL, 32'h0000_0006, OK);
        wait_msw(16'h000f, 16'h0000);
        en <= 1'b0;
        axi_wr(CTRL, 32'h0000_0001, OK);
        en <= 1'b1;
        wait_msw(16'h003f, 16'h0031);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        chk_st({msw, stb}, 32'h0);
        aresetn <= 1'b1;
        en <= 1'b0;
        @(posedge aclk);
        axi_rd(CTRL, 32'h0, 32'hffff_ffff, OK);
        end_test("abort");
        give_verdict();
    end
endmodule // test_trace_trigger_control_fsm
`default_nettype wire
